// *** pkg/ivpm_pkg.sv ***
// ----------------------------------------------------------------
// interrupt map constants
// ----------------------------------------------------------------
package ivpm_pkg;

    // sizes
    localparam int NUM_LINES      = 24;
    localparam int LINE_W         = 5;
    localparam int LVL_W          = 2;
    localparam int FIELDS_PER_REG = 4;
    localparam int NUM_LVL_REGS   = 6;
    localparam int VEC_W          = 16;
    localparam int DATA_W         = 32;
    localparam int PADDR_W        = 8;
    localparam int WORD_LSB       = 2;

    // level field reset value, lowest urgency
    localparam logic [LVL_W-1:0] LEVEL_RESET = 2'h3;

    // register byte offsets
    localparam logic [PADDR_W-1:0] OFF_LEVEL0  = 8'h00;
    localparam logic [PADDR_W-1:0] OFF_REQUEST = 8'h18;
    localparam logic [PADDR_W-1:0] OFF_ACTIVE  = 8'h1c;

    // active register field positions
    localparam int ACT_VALID_BIT = 31;
    localparam int ACT_NUM_LSB   = 24;
    localparam int ACT_LVL_LSB   = 16;
    localparam int ACT_VEC_LSB   = 0;

    // request line numbers of each source
    localparam logic [LINE_W-1:0] IRQ_EXT4    = 5'h00;
    localparam logic [LINE_W-1:0] IRQ_EXT5    = 5'h01;
    localparam logic [LINE_W-1:0] IRQ_EXT2_6  = 5'h02;
    localparam logic [LINE_W-1:0] IRQ_EXT3_7  = 5'h03;
    localparam logic [LINE_W-1:0] IRQ_CT0_LOW = 5'h05;
    localparam logic [LINE_W-1:0] IRQ_CT0_HIGH = 5'h06;
    localparam logic [LINE_W-1:0] IRQ_UART_RX = 5'h07;
    localparam logic [LINE_W-1:0] IRQ_UART_TX = 5'h08;
    localparam logic [LINE_W-1:0] IRQ_CT1_HIGH = 5'h0e;
    localparam logic [LINE_W-1:0] IRQ_ADC     = 5'h12;
    localparam logic [LINE_W-1:0] IRQ_TBT     = 5'h13;
    localparam logic [LINE_W-1:0] IRQ_WATCH   = 5'h14;
    localparam logic [LINE_W-1:0] IRQ_CT1_LOW = 5'h16;
    localparam logic [LINE_W-1:0] IRQ_FLASH   = 5'h17;

    // vector table: line 0 upper byte at top, two bytes per line
    localparam logic [VEC_W-1:0] VEC_TOP       = 16'hfffa;
    localparam logic [VEC_W-1:0] VEC_LOWER_OFS = 16'h0001;

    // upper byte address of a line's vector entry
    function automatic logic [VEC_W-1:0] vector_upper(input logic [LINE_W-1:0] line);
        vector_upper = VEC_TOP - {10'h000, line, 1'b0};
    endfunction : vector_upper

    // lower byte address follows the upper one
    function automatic logic [VEC_W-1:0] vector_lower(input logic [LINE_W-1:0] line);
        vector_lower = vector_upper(line) + VEC_LOWER_OFS;
    endfunction : vector_lower

endpackage : ivpm_pkg

// *** rtl/ivpm_arbiter.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// level and fixed-order arbiter
// ----------------------------------------------------------------
module ivpm_arbiter (
    // pending lines and their levels
    input  wire logic [ivpm_pkg::NUM_LINES-1:0]              req,
    input  wire logic [ivpm_pkg::NUM_LINES*ivpm_pkg::LVL_W-1:0] levels,
    // winner
    output logic                                             found,
    output logic [ivpm_pkg::LINE_W-1:0]                      win_num,
    output logic [ivpm_pkg::LVL_W-1:0]                       win_lvl
);

    // lowest level value wins; strict compare keeps the lower line on ties
    always_comb begin
        logic [ivpm_pkg::LVL_W-1:0] lvl;
        lvl     = '0;
        found   = 1'b0;
        win_num = '0;
        win_lvl = '0;
        for (int n = 0; n < ivpm_pkg::NUM_LINES; n++) begin
            lvl = levels[n*ivpm_pkg::LVL_W +: ivpm_pkg::LVL_W];
            if (req[n] && (!found || (lvl < win_lvl))) begin
                found   = 1'b1;
                win_num = ivpm_pkg::LINE_W'(n);
                win_lvl = lvl;
            end
        end
    end

endmodule : ivpm_arbiter

`default_nettype wire

// *** rtl/ivpm_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module ivpm_top (
    // clock and reset
    input  wire logic                               ref_clk,
    input  wire logic                               reset,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [ivpm_pkg::PADDR_W-1:0]       paddr,
    input  wire logic [ivpm_pkg::DATA_W-1:0]        pwdata,
    output logic [ivpm_pkg::DATA_W-1:0]             prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // external interrupt channels
    input  wire logic                               ext_int2,
    input  wire logic                               ext_int3,
    input  wire logic                               ext_int4,
    input  wire logic                               ext_int5,
    input  wire logic                               ext_int6,
    input  wire logic                               ext_int7,
    // composite timer halves
    input  wire logic                               ctimer0_low,
    input  wire logic                               ctimer0_high,
    input  wire logic                               ctimer1_low,
    input  wire logic                               ctimer1_high,
    // serial unit
    input  wire logic                               uart_rx_int,
    input  wire logic                               uart_tx_int,
    // other peripherals
    input  wire logic                               adc_int,
    input  wire logic                               timebase_int,
    input  wire logic                               watch_int,
    input  wire logic                               flash_int,
    // request to cpu core
    output logic                                    irq_request,
    output logic [ivpm_pkg::LINE_W-1:0]             irq_number,
    output logic [ivpm_pkg::LVL_W-1:0]              irq_level,
    output logic [ivpm_pkg::VEC_W-1:0]              vec_addr_upper,
    output logic [ivpm_pkg::VEC_W-1:0]              vec_addr_lower
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // one-hot placement of a source on its request line
    function automatic logic [ivpm_pkg::NUM_LINES-1:0] line_bit(
        input logic [ivpm_pkg::LINE_W-1:0] line,
        input logic                        src
    );
        line_bit = '0;
        line_bit[line] = src;
    endfunction : line_bit

    // word index of a byte offset
    function automatic logic [ivpm_pkg::PADDR_W-1:0] word_of(
        input logic [ivpm_pkg::PADDR_W-1:0] addr
    );
        word_of = addr >> ivpm_pkg::WORD_LSB;
    endfunction : word_of

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------

    // register kinds seen by the read mux
    typedef enum {
        KIND_NONE,
        KIND_LEVEL,
        KIND_REQUEST,
        KIND_ACTIVE
    } ivpm_kind_t;

    // level storage and pending lines
    logic [ivpm_pkg::LVL_W-1:0]                 level_field [ivpm_pkg::NUM_LINES];
    logic [ivpm_pkg::NUM_LINES-1:0]             req_q;
    wire  logic [ivpm_pkg::NUM_LINES-1:0]       raw_lines;
    wire  logic [ivpm_pkg::NUM_LINES-1:0]       req_lines;
    wire  logic [ivpm_pkg::NUM_LINES*ivpm_pkg::LVL_W-1:0] level_flat;
    wire  logic [ivpm_pkg::DATA_W-1:0]          lvl_word [ivpm_pkg::NUM_LVL_REGS];

    // arbiter result
    wire  logic                                 arb_found;
    wire  logic [ivpm_pkg::LINE_W-1:0]          arb_num;
    wire  logic [ivpm_pkg::LVL_W-1:0]           arb_lvl;

    // apb decode
    wire  logic [ivpm_pkg::PADDR_W-1:0]         addr_word;
    wire  logic [ivpm_pkg::PADDR_W-1:0]         lvl_index;
    wire  logic                                 hit_level;
    wire  logic                                 hit_request;
    wire  logic                                 hit_active;
    wire  logic                                 hit_any;
    wire  logic                                 setup_phase;
    wire  logic                                 access_phase;
    wire  logic                                 ro_write;
    wire  logic                                 bad_access;
    wire  logic                                 wr_level;

    // read path
    wire  logic [ivpm_pkg::DATA_W-1:0]          active_word;
    ivpm_kind_t                                 rd_kind;
    logic [ivpm_pkg::DATA_W-1:0]                next_prdata;

    // ----------------------------------------------------------------
    // source to request line mapping
    // ----------------------------------------------------------------

    // each source placed on its request line
    assign raw_lines =
          line_bit(ivpm_pkg::IRQ_EXT4,     ext_int4)
        | line_bit(ivpm_pkg::IRQ_EXT5,     ext_int5)
        | line_bit(ivpm_pkg::IRQ_EXT2_6,   ext_int2 | ext_int6)
        | line_bit(ivpm_pkg::IRQ_EXT3_7,   ext_int3 | ext_int7)
        | line_bit(ivpm_pkg::IRQ_CT0_LOW,  ctimer0_low)
        | line_bit(ivpm_pkg::IRQ_CT0_HIGH, ctimer0_high)
        | line_bit(ivpm_pkg::IRQ_UART_RX,  uart_rx_int)
        | line_bit(ivpm_pkg::IRQ_UART_TX,  uart_tx_int)
        | line_bit(ivpm_pkg::IRQ_CT1_HIGH, ctimer1_high)
        | line_bit(ivpm_pkg::IRQ_ADC,      adc_int)
        | line_bit(ivpm_pkg::IRQ_TBT,      timebase_int)
        | line_bit(ivpm_pkg::IRQ_WATCH,    watch_int)
        | line_bit(ivpm_pkg::IRQ_CT1_LOW,  ctimer1_low)
        | line_bit(ivpm_pkg::IRQ_FLASH,    flash_int);

    // lines that own a source; any other line is held idle
    localparam logic [ivpm_pkg::NUM_LINES-1:0] USED_LINES =
          line_bit(ivpm_pkg::IRQ_EXT4,     1'b1)
        | line_bit(ivpm_pkg::IRQ_EXT5,     1'b1)
        | line_bit(ivpm_pkg::IRQ_EXT2_6,   1'b1)
        | line_bit(ivpm_pkg::IRQ_EXT3_7,   1'b1)
        | line_bit(ivpm_pkg::IRQ_CT0_LOW,  1'b1)
        | line_bit(ivpm_pkg::IRQ_CT0_HIGH, 1'b1)
        | line_bit(ivpm_pkg::IRQ_UART_RX,  1'b1)
        | line_bit(ivpm_pkg::IRQ_UART_TX,  1'b1)
        | line_bit(ivpm_pkg::IRQ_CT1_HIGH, 1'b1)
        | line_bit(ivpm_pkg::IRQ_ADC,      1'b1)
        | line_bit(ivpm_pkg::IRQ_TBT,      1'b1)
        | line_bit(ivpm_pkg::IRQ_WATCH,    1'b1)
        | line_bit(ivpm_pkg::IRQ_CT1_LOW,  1'b1)
        | line_bit(ivpm_pkg::IRQ_FLASH,    1'b1);

    // a wrong map entry cannot raise a line with no source
    assign req_lines = raw_lines & USED_LINES;

    // snapshot of pending lines for software
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_q <= '0;
        end else begin
            req_q <= req_lines;
        end
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------

    // phases and address hits
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign addr_word    = word_of(paddr);
    assign lvl_index    = addr_word - word_of(ivpm_pkg::OFF_LEVEL0);
    assign hit_level    = (addr_word >= word_of(ivpm_pkg::OFF_LEVEL0))
                        & (lvl_index < ivpm_pkg::PADDR_W'(ivpm_pkg::NUM_LVL_REGS));
    assign hit_request  = (addr_word == word_of(ivpm_pkg::OFF_REQUEST));
    assign hit_active   = (addr_word == word_of(ivpm_pkg::OFF_ACTIVE));
    assign hit_any      = hit_level | hit_request | hit_active;

    // writes land only in level words; request and active are read-only
    assign ro_write     = pwrite & ~hit_level;

    // unmapped address, or write to a read-only word
    assign bad_access   = ~hit_any | ro_write;

    // zero wait state; error only on the access phase
    assign pready       = 1'b1;
    assign pslverr      = access_phase & bad_access;
    assign wr_level     = access_phase & pwrite & hit_level;

    // ----------------------------------------------------------------
    // level fields
    // ----------------------------------------------------------------

    // four two-bit fields per level word, line n in word n/4
    for (genvar g = 0; g < ivpm_pkg::NUM_LINES; g++) begin : g_level
        localparam int REG_IDX = g / ivpm_pkg::FIELDS_PER_REG;
        localparam int FLD_LSB = (g % ivpm_pkg::FIELDS_PER_REG) * ivpm_pkg::LVL_W;
        wire logic sel_this;

        assign sel_this = wr_level
                        & (lvl_index == ivpm_pkg::PADDR_W'(REG_IDX));

        // software sets the level of this line
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                level_field[g] <= ivpm_pkg::LEVEL_RESET;
            end else if (sel_this) begin
                level_field[g] <= pwdata[FLD_LSB +: ivpm_pkg::LVL_W];
            end
        end

        // flattened copy for the arbiter and read-back
        assign level_flat[g*ivpm_pkg::LVL_W +: ivpm_pkg::LVL_W] = level_field[g];
        assign lvl_word[REG_IDX][FLD_LSB +: ivpm_pkg::LVL_W]     = level_field[g];
    end

    // upper bits of each level word read as zero
    for (genvar r = 0; r < ivpm_pkg::NUM_LVL_REGS; r++) begin : g_lvl_pad
        localparam int USED = ivpm_pkg::FIELDS_PER_REG * ivpm_pkg::LVL_W;
        assign lvl_word[r][ivpm_pkg::DATA_W-1:USED] = '0;
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------

    // most urgent level, lowest line on ties
    ivpm_arbiter u_arbiter (
        .req     (req_lines),
        .levels  (level_flat),
        .found   (arb_found),
        .win_num (arb_num),
        .win_lvl (arb_lvl)
    );

    // registered request and vector to the cpu core
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_request    <= 1'b0;
            irq_number     <= '0;
            irq_level      <= ivpm_pkg::LEVEL_RESET;
            vec_addr_upper <= ivpm_pkg::VEC_TOP;
            vec_addr_lower <= ivpm_pkg::vector_lower('0);
        end else begin
            irq_request    <= arb_found;
            irq_number     <= arb_num;
            irq_level      <= arb_lvl;
            vec_addr_upper <= ivpm_pkg::vector_upper(arb_num);
            vec_addr_lower <= ivpm_pkg::vector_lower(arb_num);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------

    // active word: valid, line, level and upper vector address
    assign active_word = (ivpm_pkg::DATA_W'(irq_request) << ivpm_pkg::ACT_VALID_BIT)
                       | (ivpm_pkg::DATA_W'(irq_number) << ivpm_pkg::ACT_NUM_LSB)
                       | (ivpm_pkg::DATA_W'(irq_level) << ivpm_pkg::ACT_LVL_LSB)
                       | (ivpm_pkg::DATA_W'(vec_addr_upper) << ivpm_pkg::ACT_VEC_LSB);

    // which register the address selects
    assign rd_kind = hit_level   ? KIND_LEVEL
                   : hit_request ? KIND_REQUEST
                   : hit_active  ? KIND_ACTIVE
                   : KIND_NONE;

    // read mux, unmapped reads return zero
    always_comb begin
        next_prdata = '0;
        unique case (rd_kind)
            KIND_LEVEL: begin
                next_prdata = lvl_word[lvl_index[2:0]];
            end
            KIND_REQUEST: begin
                next_prdata = ivpm_pkg::DATA_W'(req_q);
            end
            KIND_ACTIVE: begin
                next_prdata = active_word;
            end
            KIND_NONE: begin
                next_prdata = '0;
            end
        endcase
    end

    // read data captured in the setup cycle, held through the access
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule : ivpm_top

`default_nettype wire

// *** sim/ivpm_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// request output checker
// ----------------------------------------------------------------
module ivpm_top_asserts (
    // clock, reset and apb handshake
    input wire logic ref_clk, reset, psel, penable, pready,
    // interrupt sources
    input wire logic ext_int2, ext_int3, ext_int4, ext_int5, ext_int6, ext_int7,
    input wire logic ctimer0_low, ctimer0_high, ctimer1_low, ctimer1_high,
    input wire logic uart_rx_int, uart_tx_int, adc_int, timebase_int, watch_int, flash_int,
    // request to cpu core
    input wire logic                          irq_request,
    input wire logic [ivpm_pkg::LINE_W-1:0]   irq_number,
    input wire logic [ivpm_pkg::VEC_W-1:0]    vec_addr_upper,
    input wire logic [ivpm_pkg::VEC_W-1:0]    vec_addr_lower
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // pending lines as the sources show them
    wire logic [23:0] src = {flash_int, ctimer1_low, 1'b0, watch_int, timebase_int, adc_int,
        3'h0, ctimer1_high, 5'h00, uart_tx_int, uart_rx_int, ctimer0_high, ctimer0_low, 1'b0,
        ext_int3 | ext_int7, ext_int2 | ext_int6, ext_int5, ext_int4};
    // sources as the design registered them; reset clears them like the outputs
    logic [23:0] src_q;
    logic        ext6_q;
    always_ff @(posedge ref_clk) begin
        src_q  <= reset ? 24'h000000 : src;
        ext6_q <= ext_int6 & ~reset;
    end
    a_ext4_line0: assert property (src_q == 24'h000001
        |-> irq_request && irq_number == 5'h00 && vec_addr_upper == 16'hfffa)
        else $error("ext4 not on line 0");
    a_ext6_line2: assert property (ext6_q && src_q == 24'h000004
        |-> irq_number == 5'h02 && vec_addr_upper == 16'hfff6) else $error("ext6 not on line 2");
    a_ct0_low: assert property (src_q == 24'h000020
        |-> irq_number == 5'h05 && vec_addr_upper == 16'hfff0) else $error("timer0 low not on line 5");
    a_ct0_high: assert property (src_q == 24'h000040
        |-> irq_number == 5'h06 && vec_addr_upper == 16'hffee) else $error("timer0 high not on line 6");
    a_ct1_high: assert property (src_q == 24'h004000
        |-> irq_number == 5'h0e && vec_addr_upper == 16'hffde) else $error("timer1 high not on line 14");
    a_ct1_low: assert property (src_q == 24'h400000
        |-> irq_number == 5'h16 && vec_addr_upper == 16'hffce) else $error("timer1 low not on line 22");
    a_vec_pair: assert property (irq_request
        |-> vec_addr_lower == vec_addr_upper + 16'h0001
        && vec_addr_upper == 16'hfffa - {10'h000, irq_number, 1'b0}) else $error("bad vector");
    a_req_follows: assert property (irq_request == (|src_q))
        else $error("request does not follow sources");
    a_win_pending: assert property (irq_request |-> src_q[irq_number])
        else $error("winner line not pending");
    a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
endmodule : ivpm_top_asserts
bind ivpm_top ivpm_top_asserts chk_u (.*);
`default_nettype wire

// *** sim/ivpm_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// cpu core taking vectored requests
// ----------------------------------------------------------------
module ivpm_cpu_model #(parameter int TAKE_DELAY = 3) (
    // clock and reset
    input wire logic         ref_clk,
    input wire logic         reset,
    // request from the map
    input wire logic         irq_request,
    input wire logic [15:0]  vec_addr_upper,
    input wire logic [15:0]  vec_addr_lower,
    // fetched vector addresses
    output logic [15:0]      taken_upper,
    output logic [15:0]      taken_lower
);
    int          cnt;
    logic [15:0] last;
    // fetch once the vector has stood for the take delay
    always_ff @(posedge ref_clk) begin
        last <= vec_addr_upper;
        if (reset) begin
            cnt <= 0;
            taken_upper <= 16'h0000;
            taken_lower <= 16'h0000;
        end else if (!irq_request || vec_addr_upper != last) begin
            cnt <= 0;
        end else if (cnt < TAKE_DELAY) begin
            cnt <= cnt + 1;
        end else begin
            taken_upper <= vec_addr_upper; // upper byte, same cycle as the lower
            taken_lower <= vec_addr_lower; // lower byte, at the next address
        end
    end
endmodule : ivpm_cpu_model
`default_nettype wire

// *** sim/tb_interrupt_vector_priority_map.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// interrupt map testbench
// ----------------------------------------------------------------
module tb_interrupt_vector_priority_map;
    logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq_request, err;
    logic [4:0]  irq_number;
    logic [1:0]  irq_level;
    logic [15:0] vec_addr_upper, vec_addr_lower, taken_upper, src = 16'h0000;
    int          n_fail = 0, total_checks = 0;
    int          line_of [16] = '{2, 3, 0, 1, 2, 3, 5, 6, 22, 14, 7, 8, 18, 19, 20, 23};
    always #5 ref_clk = ~ref_clk;
    ivpm_top dut_u (.*, .ext_int2(src[0]), .ext_int3(src[1]), .ext_int4(src[2]),
        .ext_int5(src[3]), .ext_int6(src[4]), .ext_int7(src[5]), .ctimer0_low(src[6]),
        .ctimer0_high(src[7]), .ctimer1_low(src[8]), .ctimer1_high(src[9]),
        .uart_rx_int(src[10]), .uart_tx_int(src[11]), .adc_int(src[12]),
        .timebase_int(src[13]), .watch_int(src[14]), .flash_int(src[15]));
    ivpm_cpu_model #(.TAKE_DELAY(3)) cpu_u (.ref_clk, .reset, .irq_request, .vec_addr_upper,
        .vec_addr_lower, .taken_upper, .taken_lower());
    // verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one apb transfer, result in rd and err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            results();
        end
    endtask : apb
    // set sources, then let the one-cycle latency pass
    task automatic drive(input logic [15:0] s);
        @(posedge ref_clk);
        src <= s;
        @(posedge ref_clk);
        #1;
    endtask : drive
    // compare the request outputs with a line and level
    task automatic chk_win(input int line, input logic [1:0] lvl);
        chk(irq_request, 32'h1, "request");
        chk(irq_number, line, "line");
        chk(irq_level, lvl, "level");
        chk(vec_addr_upper, 32'hfffa - 2 * line, "upper vector");
        chk(vec_addr_lower, 32'hfffb - 2 * line, "lower vector");
    endtask : chk_win
    // bound on the whole run
    initial begin
        #100000;
        n_fail++;
        results();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk(irq_request, 32'h0, "reset request");
        chk(vec_addr_upper, 32'hfffa, "reset vector");
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rd, 32'hff, "level word reset");
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped read data");
        chk(err, 32'h1, "unmapped read error");
        apb(1'b1, 8'h18, 32'h1);
        chk(err, 32'h1, "read-only write");
        for (int i = 0; i < 16; i++) begin
            drive(16'h0001 << i);
            chk_win(line_of[i], 2'h3);
            repeat (5) @(posedge ref_clk);
            #1;
            chk(taken_upper, 32'hfffa - 2 * line_of[i], "cpu fetch");
        end
        drive(16'h0000);
        chk(irq_request, 32'h0, "idle");
        drive(16'hffff);
        chk_win(0, 2'h3);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h00dc41ef, "pending lines");
        apb(1'b1, 8'h04, 32'h03);
        chk(err, 32'h0, "level write error");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h03, "level readback");
        chk_win(5, 2'h0);
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b1, 8'h0c, 32'hcf);
        apb(1'b1, 8'h14, 32'hcf);
        drive(16'hffff);
        chk_win(14, 2'h0);
        drive(16'hfdff);
        chk_win(22, 2'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h9600ffce, "active word");
        chk(err, 32'h0, "active read error");
        // mid-run reset returns levels and request to reset values
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk(irq_request, 32'h0, "mid-run reset request");
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'hff, "level word after reset");
        chk_win(0, 2'h3);
        results();
    end
endmodule : tb_interrupt_vector_priority_map
`default_nettype wire
